// ---- core/lsd_core.sv ----
// Load measurement capture, stall detect pulse and load-adaptive current scale
`timescale 1ns/1ps
module lsd_core #(
    parameter int MEAS_W = lsd_pkg::MEAS_W,
    parameter int VEL_W  = lsd_pkg::VEL_W
) (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    // Measurement side, same clock domain
    input  wire logic                   meas_valid,        // One-cycle pulse per crossing
    input  wire logic [MEAS_W-1:0]      meas_value,        // New crossing measurement
    input  wire lsd_pkg::lsd_slot_e     meas_slot,         // Which crossing
    input  wire logic [lsd_pkg::RESULT_W-1:0] legacy_load_result, // Older measurement
    input  wire logic                   legacy_valid,      // Pulse when older measurement new
    // Configuration
    input  wire logic                   load_filter_enable,
    input  wire logic                   phase_lag_comp_enable,
    input  wire logic [lsd_pkg::RESULT_W-1:0] stall_threshold,
    input  wire logic                   voltage_mode,      // 1: voltage-controlled chopper
    input  wire logic [VEL_W-1:0]       step_period_measure,
    input  wire logic [VEL_W-1:0]       lower_velocity_threshold,
    input  wire logic [VEL_W-1:0]       chopper_switch_threshold,
    input  wire lsd_pkg::lsd_adapt_cfg_s adapt_cfg,
    // Status
    output logic [MEAS_W-1:0]           crossing_meas_a_fall,
    output logic [MEAS_W-1:0]           crossing_meas_a_rise,
    output logic [MEAS_W-1:0]           crossing_meas_b_fall,
    output logic [MEAS_W-1:0]           crossing_meas_b_rise,
    output logic [lsd_pkg::RESULT_W-1:0] load_result,
    output logic                        result_valid,      // Pulse, result updated
    output logic                        stall_pulse,       // Diagnostic stall pulse
    output logic [lsd_pkg::RESULT_W-1:0] phase_lag_offset,  // Stored phase lag
    output logic                        phase_lag_apply,   // Pulse, subtract stored offset
    output logic [lsd_pkg::CS_W-1:0]    current_scale
);
    localparam int RW = lsd_pkg::RESULT_W;
    localparam int CW = lsd_pkg::CS_W;

    // ==========================================================
    // Helpers
    // ==========================================================
    // Scale a 4-bit field sum to a compare level
    function automatic logic [RW-1:0] scale_thr(input logic [5:0] f);
        scale_thr = RW'({f, 5'h00});
    endfunction : scale_thr

    // ==========================================================
    // Crossing slots
    // ==========================================================
    // Slot capture, steered by filter enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            crossing_meas_a_fall <= '0;
            crossing_meas_a_rise <= '0;
            crossing_meas_b_fall <= '0;
            crossing_meas_b_rise <= '0;
        end else if (meas_valid) begin
            if (!load_filter_enable) begin
                crossing_meas_a_fall <= meas_value;
            end else begin
                unique case (meas_slot)
                    lsd_pkg::LSD_SLOT_A_FALL: crossing_meas_a_fall <= meas_value;
                    lsd_pkg::LSD_SLOT_A_RISE: crossing_meas_a_rise <= meas_value;
                    lsd_pkg::LSD_SLOT_B_FALL: crossing_meas_b_fall <= meas_value;
                    lsd_pkg::LSD_SLOT_B_RISE: crossing_meas_b_rise <= meas_value;
                    default: ;              // Illegal slot code ignored
                endcase
            end
        end
    end

    // ==========================================================
    // Load result
    // ==========================================================
    logic [RW-1:0] next_load_result; // Candidate result
    logic [MEAS_W+1:0] slot_sum;     // Sum of four slots
    logic          cap_d;            // Delayed capture strobe

    // Sum uses slots after the capture has landed
    always_comb begin
        slot_sum = {2'b00, crossing_meas_a_fall} + {2'b00, crossing_meas_a_rise}
                 + {2'b00, crossing_meas_b_fall} + {2'b00, crossing_meas_b_rise};
        if (load_filter_enable) begin
            next_load_result = RW'(slot_sum[MEAS_W+1:1]);
        end else begin
            next_load_result = RW'({crossing_meas_a_fall, 1'b0});
        end
    end

    // Strobe delay so slots are settled
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cap_d <= 1'b0;
        end else begin
            cap_d <= meas_valid;
        end
    end

    // Result register, one update per crossing
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            load_result  <= '0;
            result_valid <= 1'b0;
        end else begin
            result_valid <= cap_d;
            if (cap_d) begin
                load_result <= next_load_result;
            end
        end
    end

    // ==========================================================
    // Stall detect
    // ==========================================================
    logic stall_window; // Mode and velocity window open
    assign stall_window = voltage_mode
                        && (step_period_measure <= lower_velocity_threshold)
                        && (step_period_measure > chopper_switch_threshold);

    // Pulse once per fresh result below threshold while the stall window is open
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stall_pulse <= 1'b0;
        end else begin
            stall_pulse <= result_valid && stall_window && (load_result < stall_threshold);
        end
    end

    // ==========================================================
    // Phase lag compensation
    // ==========================================================
    logic mode_d; // Previous chopper mode
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_d           <= 1'b1;
            phase_lag_offset <= '0;
            phase_lag_apply  <= 1'b0;
        end else begin
            mode_d          <= voltage_mode;
            phase_lag_apply <= 1'b0;
            if (phase_lag_comp_enable && mode_d && !voltage_mode) begin
                phase_lag_offset <= load_result;      // store on leaving voltage mode
            end
            if (phase_lag_comp_enable && !mode_d && voltage_mode) begin
                phase_lag_apply <= 1'b1;              // subtract on return
            end
        end
    end

    // ==========================================================
    // Adaptive current regulator
    // ==========================================================
    logic [RW-1:0] reg_load;    // Selected load input
    logic          reg_valid;   // Selected reading strobe
    logic [RW-1:0] thr_low;     // Lower compare level
    logic [RW-1:0] thr_high;    // Upper compare level
    logic [5:0]    dn_cnt;      // High readings counted
    logic [5:0]    dn_need;     // Readings per decrement
    logic [CW:0]   inc_amt;     // Increment width
    logic [CW:0]   cs_up;       // Unsaturated sum, one carry bit
    logic          adapt_on;    // Regulator enabled

    assign reg_load  = voltage_mode ? load_result : legacy_load_result;
    assign reg_valid = voltage_mode ? result_valid : legacy_valid;
    assign adapt_on  = (adapt_cfg.up_threshold != 4'h0);
    assign thr_low   = scale_thr({2'b00, adapt_cfg.up_threshold});
    assign thr_high  = scale_thr(6'({2'b00, adapt_cfg.up_threshold})
                     + 6'({2'b00, adapt_cfg.down_hysteresis}) + 6'h01);
    assign inc_amt   = (CW+1)'(6'h01 << adapt_cfg.increment_step);
    assign cs_up     = {1'b0, current_scale} + inc_amt;

    // Decrement rate decode
    always_comb begin
        unique case (adapt_cfg.decrement_rate)
            2'h0: dn_need = 6'h20;
            2'h1: dn_need = 6'h08;
            2'h2: dn_need = 6'h02;
            2'h3: dn_need = 6'h01;
        endcase
    end

    // Current scale and decrement counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            current_scale <= lsd_pkg::CS_RESET;
            dn_cnt        <= lsd_pkg::DN_CNT_RESET;
        end else if (!adapt_on) begin
            current_scale <= adapt_cfg.cs_max; // scaling off
            dn_cnt        <= '0;
        end else if (reg_valid) begin
            if (reg_load < thr_low) begin
                dn_cnt <= '0;
                current_scale <= (cs_up > {1'b0, adapt_cfg.cs_max})
                               ? adapt_cfg.cs_max : cs_up[CW-1:0];
            end else if (reg_load >= thr_high) begin
                if (dn_cnt + 6'h01 >= dn_need) begin
                    dn_cnt <= '0;
                    if (current_scale > adapt_cfg.cs_min) begin
                        current_scale <= current_scale - CW'(1);
                    end
                end else begin
                    dn_cnt <= dn_cnt + 6'h01;
                end
            end else begin
                dn_cnt <= '0; // Run of high readings broken
            end
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    property p_slot0_unfilt;
        @(posedge clk) disable iff (!rst_b)
        (meas_valid && !load_filter_enable) |=> (crossing_meas_a_fall == $past(meas_value));
    endproperty
    a_slot0_unfilt: assert property (p_slot0_unfilt) else $error("slot 0 not written");

    property p_slot_b_rise;
        @(posedge clk) disable iff (!rst_b)
        (meas_valid && load_filter_enable && meas_slot == lsd_pkg::LSD_SLOT_B_RISE)
        |=> (crossing_meas_b_rise == $past(meas_value)) && $stable(crossing_meas_a_fall);
    endproperty
    a_slot_b_rise: assert property (p_slot_b_rise) else $error("slot 3 capture wrong");

    property p_unfilt_result;
        @(posedge clk) disable iff (!rst_b)
        (meas_valid && !load_filter_enable) ##1 !load_filter_enable
        |=> (load_result == RW'({$past(meas_value, 2), 1'b0}));
    endproperty
    a_unfilt_result: assert property (p_unfilt_result) else $error("unfiltered result wrong");

    property p_filt_result;
        @(posedge clk) disable iff (!rst_b)
        (cap_d && load_filter_enable) |=> (load_result == RW'($past(slot_sum) >> 1));
    endproperty
    a_filt_result: assert property (p_filt_result) else $error("filtered mean wrong");

    property p_stall;
        @(posedge clk) disable iff (!rst_b)
        stall_pulse |-> $past(result_valid) && $past(load_result < stall_threshold);
    endproperty
    a_stall: assert property (p_stall) else $error("stall pulse without cause");

    property p_stall_window;
        @(posedge clk) disable iff (!rst_b)
        stall_pulse |-> $past(voltage_mode) && $past(step_period_measure > chopper_switch_threshold)
                        && $past(step_period_measure <= lower_velocity_threshold);
    endproperty
    a_stall_window: assert property (p_stall_window) else $error("stall outside window");

    property p_offset;
        @(posedge clk) disable iff (!rst_b)
        (phase_lag_comp_enable && mode_d && !voltage_mode) |=> (phase_lag_offset == $past(load_result));
    endproperty
    a_offset: assert property (p_offset) else $error("phase lag not stored");

    property p_disable;
        @(posedge clk) disable iff (!rst_b)
        (adapt_cfg.up_threshold == 4'h0) |=> (current_scale == $past(adapt_cfg.cs_max));
    endproperty
    a_disable: assert property (p_disable) else $error("zero field did not disable");

    property p_raise;
        @(posedge clk) disable iff (!rst_b)
        (adapt_on && reg_valid && reg_load < thr_low && cs_up <= {1'b0, adapt_cfg.cs_max})
        |=> (current_scale == $past(cs_up[CW-1:0]));
    endproperty
    a_raise: assert property (p_raise) else $error("current not raised");

    property p_lower_fast;
        @(posedge clk) disable iff (!rst_b)
        (adapt_on && reg_valid && reg_load >= thr_high && dn_need == 6'h01
         && current_scale > adapt_cfg.cs_min) |=> (current_scale == $past(current_scale) - CW'(1));
    endproperty
    a_lower_fast: assert property (p_lower_fast) else $error("current not lowered");

    // Regulator idles between readings of the selected source
    property p_hold_scale;
        @(posedge clk) disable iff (!rst_b)
        (adapt_on && !reg_valid) |=> $stable(current_scale);
    endproperty
    a_hold_scale: assert property (p_hold_scale) else $error("scale moved without reading");

    // Result never exceeds twice the largest single measurement
    property p_result_range;
        @(posedge clk) disable iff (!rst_b)
        load_result <= RW'({{MEAS_W{1'b1}}, 1'b0});
    endproperty
    a_result_range: assert property (p_result_range) else $error("result out of range");
endmodule : lsd_core

// ---- core/lsd_pkg.sv ----
// Package for the load measurement, stall detect and adaptive current block
package lsd_pkg;
    // Widths
    localparam int MEAS_W   = 8;   // One crossing measurement
    localparam int RESULT_W = 10;  // Load result, one extra bit plus margin
    localparam int VEL_W    = 20;  // Velocity compare width
    localparam int CS_W     = 5;   // Current scale width
    // Threshold scaling
    localparam int THR_SHIFT = 5;  // Multiply by 32
    // Reset values
    localparam logic [CS_W-1:0]  CS_RESET  = 5'h1f;
    localparam logic [5:0]       DN_CNT_RESET = 6'h00;
    // Crossing slots
    typedef enum logic [3:0] {
        LSD_SLOT_A_FALL = 4'h1,
        LSD_SLOT_A_RISE = 4'h2,
        LSD_SLOT_B_FALL = 4'h4,
        LSD_SLOT_B_RISE = 4'h8
    } lsd_slot_e;
    // Adaptive current settings
    typedef struct packed {
        logic [3:0] up_threshold;    // Lower threshold field
        logic [3:0] down_hysteresis; // Hysteresis field
        logic [1:0] increment_step;  // 1,2,4,8
        logic [1:0] decrement_rate;  // 32,8,2,1
        logic [CS_W-1:0] cs_max;     // Upper current limit
        logic [CS_W-1:0] cs_min;     // Lower current limit
    } lsd_adapt_cfg_s;
endpackage : lsd_pkg

// ---- bench/lsd_ctrl_model.sv ----
// Motion controller model that watches the stall output
`timescale 1ns/1ps
module lsd_ctrl_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic stall_pulse,
    output logic      motor_stop
);
    // =========
    // Stop latch, one pulse is enough to stop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) motor_stop <= 1'h0;
        else if (stall_pulse) motor_stop <= 1'h1;
    end
endmodule : lsd_ctrl_model

// ---- bench/load_stall_detect_current_adapt_test.sv ----
// Self-checking bench for load capture, stall pulse and adaptive current
`timescale 1ns/1ps
module load_stall_detect_current_adapt_test;
    // =========
    // Design signals
    logic clk = 1'h0, rst_b = 1'h0, meas_valid = 1'h0, legacy_valid = 1'h0, voltage_mode = 1'h1;
    logic load_filter_enable = 1'h0, phase_lag_comp_enable = 1'h0;
    logic [7:0] meas_value = 8'h00;
    lsd_pkg::lsd_slot_e meas_slot = lsd_pkg::LSD_SLOT_A_FALL;
    logic [9:0] legacy_load_result = 10'h000, stall_threshold = 10'h080, load_result, phase_lag_offset;
    logic [19:0] step_period_measure = 20'h00100, lower_velocity_threshold = 20'h00200;
    logic [19:0] chopper_switch_threshold = 20'h00080;
    lsd_pkg::lsd_adapt_cfg_s adapt_cfg = '{4'h0, 4'h2, 2'h0, 2'h0, 5'h1c, 5'h04};
    logic [7:0] crossing_meas_a_fall, crossing_meas_a_rise, crossing_meas_b_fall, crossing_meas_b_rise;
    logic result_valid, stall_pulse, phase_lag_apply, motor_stop;
    logic [4:0] current_scale;
    wire logic [31:0] slots_now = {crossing_meas_b_rise, crossing_meas_b_fall, crossing_meas_a_rise,
                                   crossing_meas_a_fall};
    // Bench state and reference model
    int bad_count = 0, comparisons = 0, cycles = 0, cs = 0, run = 0, lfsr = 81, res = 0, lowest = 1023, off = 0;
    int sl[4] = '{0, 0, 0, 0};
    int dn[4] = '{32, 8, 2, 1};
    int steps[4] = '{32'h200, 32'h201, 32'h80, 32'h81};
    bit seen = 1'h0;

    lsd_core i_dut (.clk, .rst_b, .meas_valid, .meas_value, .meas_slot, .legacy_load_result, .legacy_valid,
        .load_filter_enable, .phase_lag_comp_enable, .stall_threshold, .voltage_mode, .step_period_measure,
        .lower_velocity_threshold, .chopper_switch_threshold, .adapt_cfg, .crossing_meas_a_fall,
        .crossing_meas_a_rise, .crossing_meas_b_fall, .crossing_meas_b_rise, .load_result, .result_valid,
        .stall_pulse, .phase_lag_offset, .phase_lag_apply, .current_scale);
    lsd_ctrl_model i_ctrl (.clk, .rst_b, .stall_pulse, .motor_stop);

    // =========
    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            $display("FAIL %0t timeout", $time);
            close_out();
        end
    end

    // =========
    // Helpers
    function automatic int next_rand(int v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : next_rand

    task automatic chk(input bit ok, input string m);
        comparisons++;
        if (!ok) begin
            bad_count++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask : chk

    // Regulator model on one reading
    task automatic reg_model(input int r);
        int inc;
        inc = 1 << adapt_cfg.increment_step;
        if (adapt_cfg.up_threshold == 4'h0) begin
            cs = adapt_cfg.cs_max;
            return;
        end
        if (r < adapt_cfg.up_threshold * 32) begin
            cs = (cs + inc > adapt_cfg.cs_max) ? adapt_cfg.cs_max : cs + inc;
            run = 0;
        end else if (r >= (adapt_cfg.up_threshold + adapt_cfg.down_hysteresis + 1) * 32) begin
            run++;
            if (run >= dn[adapt_cfg.decrement_rate]) begin
                run = 0;
                if (cs > adapt_cfg.cs_min) cs--;
            end
        end else run = 0;
    endtask : reg_model

    // One crossing measurement, checked through slot, result, stall and scale
    task automatic meas(input int s, input int v);
        bit win;
        @(negedge clk);
        meas_valid = 1'h1;
        meas_value = 8'(v);
        meas_slot = lsd_pkg::lsd_slot_e'(4'h1 << s);
        legacy_valid = voltage_mode;
        legacy_load_result = 10'h000;
        if (!load_filter_enable) sl[0] = v;
        else if (s < 4) sl[s] = v;
        res = load_filter_enable ? (sl[0] + sl[1] + sl[2] + sl[3]) >> 1 : sl[0] * 2;
        win = voltage_mode && step_period_measure <= lower_velocity_threshold;
        win = win && step_period_measure > chopper_switch_threshold;
        if (res < lowest) lowest = res;
        @(negedge clk);
        meas_valid = 1'h0;
        legacy_valid = 1'h0;
        chk(slots_now === {8'(sl[3]), 8'(sl[2]), 8'(sl[1]), 8'(sl[0])}, "slots");
        @(negedge clk);
        chk(load_result === 10'(res) && result_valid === 1'h1, "result");
        @(negedge clk);
        if (win && res < stall_threshold) seen = 1'h1;
        chk(stall_pulse === (win && res < stall_threshold), "stall");
        if (voltage_mode) reg_model(res);
        chk(current_scale === 5'(cs), "scale after result");
    endtask : meas

    // Older reading in current-controlled mode
    task automatic legacy(input int v);
        @(negedge clk);
        legacy_valid = 1'h1;
        legacy_load_result = 10'(v);
        @(negedge clk);
        legacy_valid = 1'h0;
        reg_model(v);
        chk(current_scale === 5'(cs), "scale after reading");
    endtask : legacy

    // Chopper mode change, phase lag store and apply
    task automatic mode_to(input bit m);
        int p;
        p = 0;
        @(negedge clk);
        voltage_mode = m;
        repeat (3) begin
            @(negedge clk);
            p += (phase_lag_apply === 1'h1);
        end
        chk(p == (m && phase_lag_comp_enable), "apply pulse");
        if (!m && phase_lag_comp_enable) off = res;
        chk(phase_lag_offset === 10'(off), "offset");
    endtask : mode_to

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    // =========
    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        chk(current_scale === 5'h1f && load_result === 10'h000, "reset values");
        rst_b = 1'h1;
        @(negedge clk);
        cs = adapt_cfg.cs_max;
        chk(current_scale === 5'(cs), "disabled scale");
        adapt_cfg.up_threshold = 4'h4;
        // Unfiltered then filtered random traffic
        for (int k = 0; k < 28; k++) begin
            if (k == 12) load_filter_enable = 1'h1;
            lfsr = next_rand(lfsr);
            meas(k % 4, lfsr);
        end
        meas(4, 8'h55);
        // Stall window edges, then outside voltage mode
        load_filter_enable = 1'h0;
        for (int k = 0; k < 4; k++) begin
            step_period_measure = 20'(steps[k]);
            meas(0, 16);
        end
        voltage_mode = 1'h0;
        meas(0, 16);
        voltage_mode = 1'h1;
        stall_threshold = 10'(lowest / 2);
        meas(0, 0);
        // Phase lag handling
        meas(0, 8'h5a);
        phase_lag_comp_enable = 1'h1;
        mode_to(1'h0);
        mode_to(1'h1);
        meas(0, 8'h20);
        phase_lag_comp_enable = 1'h0;
        mode_to(1'h0);
        // Regulator on older readings, every rate and step
        for (int r = 0; r < 4; r++) begin
            adapt_cfg.decrement_rate = 2'(r);
            legacy(128);
            repeat (dn[r]) legacy(224);
        end
        for (int i = 0; i < 8; i++) begin
            adapt_cfg.increment_step = 2'(i % 4);
            legacy(127);
        end
        repeat (30) legacy(224);
        adapt_cfg.up_threshold = 4'h0;
        legacy(10);
        chk(motor_stop === seen, "controller stop");
        close_out();
    end
endmodule : load_stall_detect_current_adapt_test
